/* bench/pulse_source.sv */
// External pulse source for the event input pin.
// Assumes bursts are started just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
  // Clock.
  input wire core_clk,
  // Pin.
  output logic pin
);
  // Idles high so the first fall is a real event.
  initial pin = 1'b1;
  // levels held two cycles or more
  task automatic burst(input int n, input int hold);
    repeat (n) begin
      pin <= 1'b0;
      repeat (hold) @(posedge core_clk);
      pin <= 1'b1;
      repeat (hold) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the timer channel.
// Assumes the checker is bound and the pulse source drives the event pin.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.vh"
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_rdata, n, c;
  logic event_input_pin, divider_out_pin, match_interrupt;
  logic [7:0] exp_q [$];
  logic [7:0] rv [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  timer_channel timer_channel_i (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_input_pin(event_input_pin), .divider_out_pin(divider_out_pin),
    .match_interrupt(match_interrupt));
  pulse_source pulse_source_i (.core_clk(core_clk), .pin(event_input_pin));
  // Core clock.
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One register access; a read notes the value it expects.
  task automatic acc(input bit w, input logic [2:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  // Bounded wait for the pin (s set) or the interrupt to reach a level.
  // Outputs are looked at on the falling edge, where they have settled.
  task automatic wt(input bit s, input logic v, input int lim);
    @(negedge core_clk);
    while ((s ? divider_out_pin : match_interrupt) !== v && lim > 0) begin
      @(negedge core_clk);
      lim--;
    end
    chk({7'h00, s ? divider_out_pin : match_interrupt}, {7'h00, v});
    @(posedge core_clk);
  endtask
  // Compares each answer with the oldest note.
  always @(posedge core_clk) begin
    rd_q <= reg_rd;
    if (rd_q) chk(reg_rdata, exp_q.pop_front());
  end
  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      print_verdict;
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(98));
    n = 8'(2 + $urandom % 8);
    c = 8'(4 + $urandom % 12);
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    foreach (rv[i]) acc(0, 3'(i), rv[i]);
    acc(1, `ADDR_MASK, 8'h01);
    acc(1, `ADDR_COMPARE, 8'h01);
    acc(1, `ADDR_CTRL, 8'h68);
    wt(0, 1'b1, 20);
    acc(1, `ADDR_CTRL, 8'h60);
    acc(0, `ADDR_COUNT, 8'h00);
    acc(0, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_STATUS, 8'h01);
    acc(0, `ADDR_STATUS, 8'h00);
    acc(1, `ADDR_COMPARE, n);
    acc(1, `ADDR_CTRL, 8'h78);
    pulse_source_i.burst(n - 1, 2 + $urandom % 4);
    repeat (8) @(posedge core_clk);
    acc(0, `ADDR_COUNT, n - 8'h01);
    acc(0, `ADDR_STATUS, 8'h00);
    pulse_source_i.burst(1, 2);
    repeat (8) @(posedge core_clk);
    acc(0, `ADDR_COUNT, 8'h00);
    acc(0, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_MASK, 8'h00);
    acc(1, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_COMPARE, 8'h03);
    acc(1, `ADDR_CTRL, 8'h11);
    acc(0, `ADDR_CTRL, 8'h11);
    acc(1, `ADDR_CTRL, 8'h19);
    wt(1, 1'b0, 600);
    chk({7'h00, match_interrupt}, 8'h00);
    acc(0, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_MASK, 8'h01);
    wt(0, 1'b1, 4);
    // The divider pin is watched directly; no port latch sits in between.
    acc(1, `ADDR_COMPARE, c);
    acc(1, `ADDR_CTRL, 8'h61);
    acc(1, `ADDR_CTRL, 8'h69);
    repeat (700) @(posedge core_clk);
    wt(1, 1'b0, 40);
    wt(1, 1'b1, 40);
    acc(1, `ADDR_CTRL, 8'h61);
    repeat (40) @(posedge core_clk);
    chk({7'h00, divider_out_pin}, 8'h01);
    acc(1, `ADDR_CTRL, 8'he1);
    @(posedge core_clk);
    chk({7'h00, divider_out_pin}, 8'h00);
    acc(1, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_COMPARE, 8'hff);
    acc(1, `ADDR_CTRL, 8'h68);
    repeat (4) @(posedge core_clk);
    acc(1, `ADDR_COMPARE, 8'h28);
    wt(0, 1'b1, 60);
    print_verdict;
  end
endmodule
`default_nettype wire

/* bench/timer_channel_asserts.sv */
// Port checker for the timer channel.
// Assumes one core clock; bound to timer_channel below.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.vh"
module timer_channel_asserts (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Register port.
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Outputs.
  input wire divider_out_pin,
  input wire match_interrupt
);
  logic [7:0] ctrl_q, cmp_q, len_q;
  logic [9:0] age_q;
  logic mask_q, pin_q, rdc_q;
  wire wc = reg_wr && reg_addr == `ADDR_CTRL;
  wire ws = reg_wr && reg_addr == `ADDR_STATUS;
  wire dv = ctrl_q[6:0] == 7'h69;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Shadows the written registers, the setup age and the pin run length.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 8'h00;
      cmp_q <= 8'hff;
      mask_q <= 1'b0;
      pin_q <= 1'b1;
      rdc_q <= 1'b0;
      len_q <= 8'h00;
      age_q <= 10'h000;
    end else begin
      pin_q <= divider_out_pin;
      rdc_q <= reg_rd && reg_addr == `ADDR_COMPARE;
      len_q <= (divider_out_pin != pin_q) ? 8'h00 : len_q + 8'h01;
      age_q <= (reg_wr && reg_addr < 3'h2) ? 10'h000 : age_q + {9'h000, age_q != 10'h3ff};
      if (wc) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_COMPARE) cmp_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_MASK) mask_q <= reg_wdata[0];
    end
  end
  property p_rd_cmp; rdc_q |-> reg_rdata == $past(cmp_q); endproperty
  a_rd_cmp: assert property (p_rd_cmp) else $error("compare readback");
  property p_rst; $rose(reset_n) |-> divider_out_pin && !match_interrupt; endproperty
  a_rst: assert property (p_rst) else $error("reset levels");
  property p_masked; !mask_q && !$past(mask_q) |-> !match_interrupt; endproperty
  a_masked: assert property (p_masked) else $error("masked interrupt");
  property p_hold; (!ctrl_q[3] && !wc) [*3] |-> $stable(divider_out_pin); endproperty
  a_hold: assert property (p_hold) else $error("stopped pin moved");
  property p_half; dv && age_q > 10'd600 && $changed(divider_out_pin) |-> len_q == cmp_q - 8'h01;
  endproperty
  a_half: assert property (p_half) else $error("half period");
  property p_tog; dv && age_q > 10'd4 && mask_q && $past(mask_q) && $past(mask_q, 2) && !$past(ws)
    && $changed(divider_out_pin) |-> match_interrupt; endproperty
  a_tog: assert property (p_tog) else $error("toggle without interrupt");
  property p_load; wc && !reg_wdata[3] |-> ##2 divider_out_pin == !$past(reg_wdata[7], 2);
  endproperty
  a_load: assert property (p_load) else $error("flop load");
  property p_quiet; !$past(ctrl_q[3]) && $past(mask_q, 2) |-> !$rose(match_interrupt); endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt while stopped");
  c_tog: cover property ($changed(divider_out_pin));
  c_irq: cover property ($rose(match_interrupt));
  c_rd: cover property (rdc_q);
endmodule
bind timer_channel timer_channel_asserts timer_channel_asserts_i (.core_clk(core_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .divider_out_pin(divider_out_pin),
  .match_interrupt(match_interrupt));
`default_nettype wire

/* verilog/edge_sampler.v */
// Synchroniser and falling-edge detector for the event input pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

module edge_sampler (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Pin and edge pulse.
  input wire pin,
  output reg fall
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // Two-flop synchroniser, then edge detect on the second stage only.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
      fall <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
      fall <= last_q & ~sync_q;
    end
  end

endmodule
`default_nettype wire

/* verilog/tick_prescaler.v */
// Free-running prescaler giving one-cycle tick pulses per clock select.
// Assumes one core clock; tick lasts exactly one core cycle.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.vh"

module tick_prescaler #(
  parameter WIDTH = `PRESCALE_BITS
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Select and tick.
  input wire [2:0] clk_sel,
  output reg tick
);

  reg [WIDTH-1:0] div_q;
  reg hit;

  // Divider counts every core cycle.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= {WIDTH{1'b0}};
    end else begin
      div_q <= div_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Tick when the low bits selected by clk_sel wrap to all ones.
  always @* begin
    case (clk_sel)
      `SEL_DIV2048: hit = &div_q[10:0];
      `SEL_DIV128: hit = &div_q[6:0];
      `SEL_DIV32: hit = &div_q[4:0];
      `SEL_DIV8: hit = &div_q[2:0];
      `SEL_DIV2: hit = div_q[0];
      `SEL_DIV1: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Registered tick pulse.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 1'b0;
    end else begin
      tick <= hit;
    end
  end

endmodule
`default_nettype wire

/* verilog/timer_channel.v */
// One 8-bit timer/counter channel: interval timer, event counter and
// divider output modes, with a plain register port and one interrupt.
// Assumes a single core clock and an asynchronous external event pin.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.vh"

// Contract
// - Timer mode counts ticks, clears on match
// - Compare register takes effect immediately
// - Event mode counts synchronised falling edges
// - Event match interrupts and clears counter
// - Event mode compare also unbuffered
// - Divider match toggles flop, clears, interrupts
// - Divider gives fifty percent square wave
// - Divider pin is inverse of flop
// - Flop loadable by control, reset zero
// - Stopped divider pin holds its level
// - Control 11h configures, 19h starts divider
module timer_channel (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Register port.
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // External event pin.
  input wire event_input_pin,
  // Outputs.
  output reg divider_out_pin,
  output reg match_interrupt
);

  reg [7:0] channel_control_reg;
  reg [7:0] compare_value_reg;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg output_flop;
  reg match_stat_q;
  reg match_mask_q;
  reg match_evt;
  reg step;
  wire tick;
  wire fall;
  wire [2:0] mode;
  wire [2:0] clk_sel;
  wire running;
  wire divider_sel;

  // Field decode of the control register.
  assign mode = channel_control_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign clk_sel = channel_control_reg[`CTRL_CLK_HI:`CTRL_CLK_LO];
  assign running = channel_control_reg[`CTRL_RUN_BIT];
  // Divider output when mode is 1 with an internal clock; event mode uses the pin.
  assign divider_sel = (mode == `MODE_DIVIDER) && (clk_sel != `SEL_EXT);

  // Internal prescaled clock enable.
  tick_prescaler #(
    .WIDTH(`PRESCALE_BITS)
  ) u_prescaler (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_sel(clk_sel),
    .tick(tick)
  );

  // Event pin synchronised before any edge detection.
  edge_sampler u_edge (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(event_input_pin),
    .fall(fall)
  );

  // Pick the count source and spot a match against the live compare value.
  always @* begin
    if (clk_sel == `SEL_EXT) begin
      step = fall;
    end else begin
      step = tick;
    end
    if (!running) begin
      step = 1'b0;
    end
    count_d = count_q + 8'h01;
    match_evt = step && (count_d == compare_value_reg);
    if (match_evt) begin
      count_d = 8'h00;
    end
  end

  // Counter advances only on a step; holds when stopped.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
    end else if (step) begin
      count_q <= count_d;
    end
  end

  // Control and compare registers; compare write lands directly.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_control_reg <= `CTRL_RESET;
      compare_value_reg <= `COMPARE_RESET;
      match_mask_q <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CTRL: channel_control_reg <= reg_wdata;
        `ADDR_COMPARE: compare_value_reg <= reg_wdata;
        `ADDR_MASK: match_mask_q <= reg_wdata[`STAT_MATCH_BIT];
        default: ;
      endcase
    end
  end

  // Output flop: loaded from the control bit, toggled on divider match.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      output_flop <= 1'b0;
    end else if (reg_wr && (reg_addr == `ADDR_CTRL) && !reg_wdata[`CTRL_RUN_BIT]) begin
      output_flop <= reg_wdata[`CTRL_FLOP_BIT];
    end else if (reg_wr && (reg_addr == `ADDR_CTRL) && !running) begin
      output_flop <= reg_wdata[`CTRL_FLOP_BIT];
    end else if (match_evt && divider_sel) begin
      output_flop <= ~output_flop;
    end
  end

  // Pin mirrors the inverted flop; the control write that stops it loads the flop from bit 7.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divider_out_pin <= 1'b1;
    end else begin
      divider_out_pin <= ~output_flop;
    end
  end

  // Sticky match status; a new match wins over a write-one clear.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_stat_q <= 1'b0;
    end else if (match_evt) begin
      match_stat_q <= 1'b1;
    end else if (reg_wr && (reg_addr == `ADDR_STATUS) && reg_wdata[`STAT_MATCH_BIT]) begin
      match_stat_q <= 1'b0;
    end
  end

  // Level interrupt from the masked status.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_interrupt <= 1'b0;
    end else begin
      match_interrupt <= (match_stat_q | match_evt) & match_mask_q &
        ~(reg_wr && (reg_addr == `ADDR_STATUS) && reg_wdata[`STAT_MATCH_BIT] && !match_evt);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: reg_rdata <= channel_control_reg;
        `ADDR_COMPARE: reg_rdata <= compare_value_reg;
        `ADDR_COUNT: reg_rdata <= count_q;
        `ADDR_STATUS: reg_rdata <= {7'h00, match_stat_q};
        `ADDR_MASK: reg_rdata <= {7'h00, match_mask_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* verilog/timer_defines.vh */
// Constants for the 8-bit timer/counter channel.
// Assumes a single 100 MHz core clock; included by bare name.
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// Register addresses (word index on the plain register port).
`define ADDR_CTRL 3'h0
`define ADDR_COMPARE 3'h1
`define ADDR_COUNT 3'h2
`define ADDR_STATUS 3'h3
`define ADDR_MASK 3'h4

// Control register field positions.
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 2
`define CTRL_RUN_BIT 3
`define CTRL_CLK_LO 4
`define CTRL_CLK_HI 6
`define CTRL_FLOP_BIT 7

// Mode encodings in control bits 2:0.
`define MODE_TIMER 3'h0
`define MODE_EVENT 3'h1
`define MODE_DIVIDER 3'h1

// Reset values.
`define CTRL_RESET 8'h00
`define COMPARE_RESET 8'hff
`define MASK_RESET 8'h00

// Status bit positions.
`define STAT_MATCH_BIT 0

// Prescaler width and clock-select codes.
`define PRESCALE_BITS 11
`define SEL_DIV2048 3'h0
`define SEL_DIV128 3'h1
`define SEL_DIV32 3'h2
`define SEL_DIV8 3'h3
`define SEL_DIV2 3'h5
`define SEL_DIV1 3'h6
`define SEL_EXT 3'h7

`endif
